/* rtl/msp_baud_timer.sv */
// dedicated bit rate timer of the serial port
module msp_baud_timer #(
    parameter int DIV_W = msp_pkg::DIV_W
) (
    input  wire logic             clock_i,
    input  wire logic             resetn_i,
    input  wire logic [DIV_W-1:0] divisor_i,
    input  wire logic [DIV_W-1:0] floor_i,
    output logic                  tick_o
);
    logic [DIV_W-1:0] count_q;
    wire  [DIV_W-1:0] limit = (divisor_i < floor_i) ? floor_i : divisor_i;
    wire              wrap  = (count_q >= limit - 1'b1);

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            count_q <= '0;
            tick_o  <= 1'b0;
        end else begin
            count_q <= wrap ? '0 : count_q + 1'b1;
            tick_o  <= wrap;
        end
    end
endmodule // msp_baud_timer

/* rtl/msp_pkg.sv */
// constants and types shared by the serial port files
package msp_pkg;
    localparam int          DATA_W          = 8;
    localparam int          DIV_W           = 16;
    localparam int          ASYNC_OVERSAMP  = 16;
    localparam int          CODEC_MIN_DIV   = 4;
    localparam int          TX_HOLD_BIT     = 11;
    localparam int          CTRL_W          = 16;
    localparam logic [15:0] CTRL_RESET      = 16'h0800;
    localparam logic [15:0] DIV_RESET       = 16'h0000;
    localparam int          FLAG_RX_BIT     = 0;
    localparam int          FLAG_TX_BIT     = 1;
    localparam int          MODE_LSB        = 0;
    localparam int          SEVEN_BIT       = 2;
    localparam int          PARITY_EN_BIT   = 3;
    localparam int          EVEN_BIT        = 4;
    localparam int          SLAVE_BIT       = 5;
    localparam int          PROTO2_BIT      = 6;
    localparam int          FS_INT_BIT      = 7;
    localparam int          NODE_ADDR_LSB   = 8;
    localparam logic [1:0]  MODE_SYNC       = 2'h0;
    localparam logic [1:0]  MODE_ASYNC      = 2'h1;
    localparam logic [1:0]  MODE_CODEC      = 2'h2;
    typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_PAR, ST_STOP} msp_state_type;
endpackage

/* rtl/msp_serial_port.sv */
// multi-mode serial port: synchronous, asynchronous and codec modes
// How it works
// - a dedicated baud timer of its own makes the internal bit clock.
// - the only interrupt requests are receive buffer full and transmit buffer empty.
// - synchronous mode is half duplex and may run one bit per system clock.
// - in synchronous slave mode the bit clock comes from the link and is not driven.
// - with the second address protocol in synchronous mode the receiver drops words until one matches the node.
// - with the first address protocol every received word is passed to software.
// - synchronous sending waits for the hold bit, which a one in the clear register clears.
// - asynchronous mode is full duplex with an internal rate of at most clock over sixteen.
// - the asynchronous receiver flags parity, framing and overrun errors.
// - codec mode is full duplex at no more than a quarter of the clock rate when the bit clock is made here.
// - codec frame syncs are either made here or, for the receiver only, taken from the codec.
// - codec words are delivered as received, without expansion to linear.
// - the character format has seven-bit length, parity enable and even parity.
// - the baud divisor register sets the asynchronous bit rate.
// - ones in the flag clear register clear the matching pending flags.
// - the pins are shared by function between the modes.
module msp_serial_port (
    input  wire logic        clock_i,
    input  wire logic        resetn_i,
    input  wire logic [15:0] serial_control_reg_i,
    input  wire logic        serial_control_we_i,
    input  wire logic [15:0] serial_control_clear_reg_i,
    input  wire logic        serial_control_clear_we_i,
    input  wire logic [15:0] baud_divisor_reg_i,
    input  wire logic [1:0]  int_flag_clear_reg_i,
    input  wire logic        int_flag_clear_we_i,
    output logic [15:0]      serial_control_o,
    input  wire logic        tx_valid_i,
    input  wire logic [7:0]  tx_data_i,
    output logic             tx_ready_o,
    output logic             rx_valid_o,
    output logic [7:0]       rx_data_o,
    input  wire logic        rx_ready_i,
    output logic             rx_full_irq,
    output logic             tx_empty_irq,
    output logic             parity_err_o,
    output logic             framing_err_o,
    output logic             overrun_err_o,
    input  wire logic        rx_data_pin_i,
    output logic             rx_data_pin_o,
    output logic             rx_data_pin_oe_o,
    output logic             tx_data_pin_o,
    input  wire logic        tx_clk_pin_i,
    output logic             tx_clk_pin_oe_o,
    input  wire logic        codec_rx_bitclock_pin,
    input  wire logic        codec_tx_bitclock_pin,
    input  wire logic        rx_frame_sync_pin_i,
    output logic             rx_frame_sync_pin_o,
    output logic             rx_frame_sync_pin_oe_o,
    input  wire logic        tx_frame_sync_pin_i,
    output logic             tx_frame_sync_pin_o,
    output logic             tx_frame_sync_pin_oe_o
);
    logic [15:0] ctrl_q;
    logic [1:0]  flag_q;
    logic [4:0]  s1_q;
    logic [4:0]  s2_q;
    logic [4:0]  s3_q;

    // control register, hold bit cleared by a one in the clear register
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            ctrl_q <= msp_pkg::CTRL_RESET;
        end else if (serial_control_we_i) begin
            ctrl_q <= serial_control_reg_i;
        end else if (serial_control_clear_we_i) begin
            ctrl_q <= ctrl_q & ~serial_control_clear_reg_i;
        end
    end
    assign serial_control_o = ctrl_q;

    wire [1:0] mode      = ctrl_q[msp_pkg::MODE_LSB +: 2];
    wire       is_sync   = (mode == msp_pkg::MODE_SYNC);
    wire       is_async  = (mode == msp_pkg::MODE_ASYNC);
    wire       is_codec  = (mode == msp_pkg::MODE_CODEC);
    wire       seven     = ctrl_q[msp_pkg::SEVEN_BIT];
    wire       par_en    = ctrl_q[msp_pkg::PARITY_EN_BIT];
    wire       even      = ctrl_q[msp_pkg::EVEN_BIT];
    wire       slave     = ctrl_q[msp_pkg::SLAVE_BIT];
    wire       proto2    = ctrl_q[msp_pkg::PROTO2_BIT];
    wire       fs_int    = ctrl_q[msp_pkg::FS_INT_BIT];
    wire [7:0] node_addr = ctrl_q[msp_pkg::NODE_ADDR_LSB +: 8];
    wire       tx_hold   = ctrl_q[msp_pkg::TX_HOLD_BIT];

    // pin inputs through two flops: data, tx clock, codec clocks, frame sync
    wire [4:0] pins_raw = {rx_frame_sync_pin_i, codec_tx_bitclock_pin,
                           codec_rx_bitclock_pin, tx_clk_pin_i, rx_data_pin_i};
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            // data line idles high, clocks and frame syncs idle low
            s1_q <= 5'h01;
            s2_q <= 5'h01;
            s3_q <= 5'h01;
        end else begin
            s1_q <= pins_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    wire rxd       = s2_q[0];
    wire rxd_fall  = ~s2_q[0] & s3_q[0];
    wire ext_rise  = s2_q[1] & ~s3_q[1];
    wire crx_fall  = ~s2_q[2] & s3_q[2];
    wire ctx_rise  = s2_q[3] & ~s3_q[3];
    wire fsr_rise  = s2_q[4] & ~s3_q[4];

    // timer floor: one in async (sixteen ticks per bit), four in codec, one in sync
    wire [15:0] floor = is_async ? 16'h0001 :
                        is_codec ? 16'(msp_pkg::CODEC_MIN_DIV) : 16'h0001;
    logic tick;
    msp_baud_timer #(.DIV_W(msp_pkg::DIV_W)) u_timer (
        .clock_i   (clock_i),
        .resetn_i  (resetn_i),
        .divisor_i (baud_divisor_reg_i),
        .floor_i   (floor),
        .tick_o    (tick)
    );

    // sixteen ticks per async bit; sync master runs straight off the tick
    logic [3:0] os_q;
    always_ff @(posedge clock_i) begin
        if (!resetn_i) os_q <= 4'h0;
        else if (tick) os_q <= os_q + 4'h1;
    end
    wire async_bit = tick && (os_q == 4'hf);
    wire sync_bit  = slave ? ext_rise : tick;
    wire codec_bit = fs_int ? tick : ctx_rise;
    wire tx_bit    = is_async ? async_bit : is_codec ? codec_bit : sync_bit;

    assign tx_clk_pin_oe_o = is_sync && !slave;
    assign rx_data_pin_o   = 1'b0;
    assign rx_data_pin_oe_o = 1'b0;

    // transmit buffer feeding the shifter
    logic       tb_valid;
    logic [7:0] tb_data;
    logic       tb_take;
    msp_skid_buf #(.W(8)) u_txbuf (
        .clock_i     (clock_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (tx_valid_i),
        .in_data_i   (tx_data_i),
        .in_ready_o  (tx_ready_o),
        .out_valid_o (tb_valid),
        .out_data_o  (tb_data),
        .out_ready_i (tb_take)
    );

    msp_pkg::msp_state_type tx_st_q;
    logic [7:0] tx_sh_q;
    logic [2:0] tx_n_q;
    logic       tx_par_q;
    logic       txd_q;
    wire [2:0]  last_bit   = seven ? 3'h6 : 3'h7;
    // sync and codec put bit 0 out at the take, so one shift fewer
    wire [2:0]  tx_last    = is_async ? last_bit : last_bit - 3'h1;
    wire        tx_allowed = !(is_sync && tx_hold);
    assign tb_take = tx_bit && (tx_st_q == msp_pkg::ST_IDLE) && tb_valid && tx_allowed;

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            tx_st_q  <= msp_pkg::ST_IDLE;
            tx_sh_q  <= 8'h00;
            tx_n_q   <= 3'h0;
            tx_par_q <= 1'b0;
            txd_q    <= 1'b1;
        end else if (tx_bit) begin
            case (tx_st_q)
                msp_pkg::ST_IDLE: begin
                    txd_q <= 1'b1;
                    if (tb_take) begin
                        tx_sh_q  <= tb_data;
                        tx_n_q   <= 3'h0;
                        tx_par_q <= !even;
                        txd_q    <= is_async ? 1'b0 : tb_data[0];
                        tx_st_q  <= msp_pkg::ST_DATA;
                    end
                end
                msp_pkg::ST_DATA: begin
                    tx_par_q <= tx_par_q ^ tx_sh_q[0];
                    if (is_async) begin
                        txd_q   <= tx_sh_q[0];
                        tx_sh_q <= tx_sh_q >> 1;
                    end else begin
                        txd_q   <= tx_sh_q[1];
                        tx_sh_q <= tx_sh_q >> 1;
                    end
                    tx_n_q <= tx_n_q + 3'h1;
                    if (tx_n_q == tx_last) begin
                        tx_st_q <= (is_async && par_en) ? msp_pkg::ST_PAR :
                                   is_async ? msp_pkg::ST_STOP : msp_pkg::ST_IDLE;
                    end
                end
                msp_pkg::ST_PAR: begin
                    txd_q   <= tx_par_q;
                    tx_st_q <= msp_pkg::ST_STOP;
                end
                msp_pkg::ST_STOP: begin
                    txd_q   <= 1'b1;
                    tx_st_q <= msp_pkg::ST_IDLE;
                end
                default: tx_st_q <= msp_pkg::ST_IDLE;
            endcase
        end
    end
    assign tx_data_pin_o = txd_q;

    // internal frame syncs in codec mode
    logic [3:0] fs_cnt_q;
    logic       fs_q;
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            fs_cnt_q <= 4'h0;
            fs_q     <= 1'b0;
        end else if (tick) begin
            fs_cnt_q <= fs_cnt_q + 4'h1;
            fs_q     <= (fs_cnt_q == 4'h0);
        end
    end
    assign tx_frame_sync_pin_o    = fs_q;
    assign rx_frame_sync_pin_o    = fs_q;
    assign tx_frame_sync_pin_oe_o = is_codec && fs_int;
    assign rx_frame_sync_pin_oe_o = is_codec && fs_int;
    wire   frame_start = fs_int ? (tick && fs_cnt_q == 4'h0) : fsr_rise;

    // receiver
    msp_pkg::msp_state_type rx_st_q;
    logic [7:0] rx_sh_q;
    logic [2:0] rx_n_q;
    logic [3:0] rx_os_q;
    logic       rx_par_q;
    logic       addr_ok_q;
    logic       rx_skip_q;
    logic       word_done;
    logic [7:0] word_val;
    logic       word_perr;
    wire [7:0]  shifted = {rxd, rx_sh_q[7:1]};
    wire [7:0]  aligned = seven ? {1'b0, shifted[7:1]} : shifted;
    wire        sync_rx_bit  = is_sync && sync_bit && !tx_allowed;
    wire        codec_rx_bit = is_codec && (fs_int ? tick : crx_fall);
    wire        samp_bit     = is_async ? (tick && rx_os_q == 4'h7) :
                               (sync_rx_bit || codec_rx_bit);
    wire        start_edge   = is_async ? rxd_fall : is_codec ? frame_start : sync_rx_bit;

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            rx_st_q   <= msp_pkg::ST_IDLE;
            rx_sh_q   <= 8'h00;
            rx_n_q    <= 3'h0;
            rx_os_q   <= 4'h0;
            rx_par_q  <= 1'b0;
            rx_skip_q <= 1'b0;
            framing_err_o <= 1'b0;
            parity_err_o  <= 1'b0;
        end else begin
            if (tick) rx_os_q <= rx_os_q + 4'h1;
            case (rx_st_q)
                msp_pkg::ST_IDLE: if (start_edge) begin
                    rx_os_q  <= 4'h0;
                    rx_n_q   <= 3'h0;
                    rx_par_q <= !even;
                    rx_skip_q <= is_async;
                    rx_st_q  <= msp_pkg::ST_DATA;
                end
                msp_pkg::ST_DATA: if (samp_bit && rx_skip_q) begin
                    // middle of the start bit: a high line means a glitch
                    rx_skip_q <= 1'b0;
                    if (rxd) rx_st_q <= msp_pkg::ST_IDLE;
                end else if (samp_bit) begin
                    rx_sh_q  <= shifted;
                    rx_par_q <= rx_par_q ^ rxd;
                    rx_n_q   <= rx_n_q + 3'h1;
                    if (rx_n_q == last_bit) begin
                        rx_st_q <= (is_async && par_en) ? msp_pkg::ST_PAR :
                                   is_async ? msp_pkg::ST_STOP : msp_pkg::ST_IDLE;
                    end
                end
                msp_pkg::ST_PAR: if (samp_bit) begin
                    parity_err_o <= (rxd != rx_par_q);
                    rx_st_q      <= msp_pkg::ST_STOP;
                end
                msp_pkg::ST_STOP: if (samp_bit) begin
                    framing_err_o <= !rxd;
                    rx_st_q       <= msp_pkg::ST_IDLE;
                end
                default: rx_st_q <= msp_pkg::ST_IDLE;
            endcase
        end
    end
    wire rx_end = samp_bit && ((rx_st_q == msp_pkg::ST_STOP) ||
                  (!is_async && rx_st_q == msp_pkg::ST_DATA && rx_n_q == last_bit));
    wire [7:0] stop_word = seven ? {1'b0, rx_sh_q[7:1]} : rx_sh_q;
    assign word_val  = (rx_st_q == msp_pkg::ST_STOP) ? stop_word : aligned;

    // address filter: in sync mode protocol two drops words until one names this node
    always_ff @(posedge clock_i) begin
        if (!resetn_i) addr_ok_q <= 1'b0;
        else if (!proto2 || !is_sync) addr_ok_q <= 1'b0;
        else if (rx_end && word_val == node_addr) addr_ok_q <= 1'b1;
    end
    assign word_done = rx_end && (!is_sync || !proto2 || addr_ok_q);

    logic rb_ready;
    msp_skid_buf #(.W(8)) u_rxbuf (
        .clock_i     (clock_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (word_done),
        .in_data_i   (word_val),
        .in_ready_o  (rb_ready),
        .out_valid_o (rx_valid_o),
        .out_data_o  (rx_data_o),
        .out_ready_i (rx_ready_i)
    );

    always_ff @(posedge clock_i) begin
        if (!resetn_i) overrun_err_o <= 1'b0;
        else if (word_done && !rb_ready) overrun_err_o <= 1'b1;
        else if (int_flag_clear_we_i && int_flag_clear_reg_i[msp_pkg::FLAG_RX_BIT])
            overrun_err_o <= 1'b0;
    end

    // pending flags; a new event wins over a clear in the same cycle
    wire [1:0] set_ev = {tb_take, word_done && rb_ready};
    wire [1:0] clr_ev = int_flag_clear_we_i ? int_flag_clear_reg_i : 2'h0;
    always_ff @(posedge clock_i) begin
        if (!resetn_i) flag_q <= 2'h0;
        else flag_q <= set_ev | (flag_q & ~clr_ev);
    end
    assign rx_full_irq  = flag_q[msp_pkg::FLAG_RX_BIT];
    assign tx_empty_irq = flag_q[msp_pkg::FLAG_TX_BIT];

    chk_flag_set_wins: assert property (@(posedge clock_i) disable iff (!resetn_i)
        set_ev[0] |=> rx_full_irq) else $error("rx flag lost to clear");
    chk_flag_clear: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (clr_ev[1] && !set_ev[1]) |=> !tx_empty_irq) else $error("tx flag not cleared");
    chk_hold_blocks: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (is_sync && tx_hold) |-> !tb_take) else $error("sync send while held");
    chk_slave_clk: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (is_sync && slave) |-> !tx_clk_pin_oe_o) else $error("slave drives clock");
    chk_fs_drive: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (is_codec && !fs_int) |-> !tx_frame_sync_pin_oe_o) else $error("fs driven");
    chk_async_rate: assert property (@(posedge clock_i) disable iff (!resetn_i)
        async_bit |=> !async_bit [*8]) else $error("async bit too fast");
    chk_overrun: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (word_done && !rb_ready) |=> overrun_err_o) else $error("overrun missed");
    chk_stop_idle: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (is_async && tx_st_q == msp_pkg::ST_STOP && tx_bit) |=> txd_q) else $error("no stop");
endmodule // msp_serial_port

/* rtl/msp_skid_buf.sv */
// two-entry buffer with valid and ready on both sides
module msp_skid_buf #(
    parameter int W = msp_pkg::DATA_W
) (
    input  wire logic         clock_i,
    input  wire logic         resetn_i,
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    output logic              out_valid_o,
    output logic [W-1:0]      out_data_o,
    input  wire logic         out_ready_i
);
    logic [W-1:0] mem_q [2];
    logic         wr_q;
    logic         rd_q;
    logic [1:0]   cnt_q;
    wire          push = in_valid_i && in_ready_o;
    wire          pop  = out_valid_o && out_ready_i;

    assign in_ready_o  = (cnt_q != 2'h2);
    assign out_valid_o = (cnt_q != 2'h0);
    assign out_data_o  = mem_q[rd_q];

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            wr_q     <= 1'b0;
            rd_q     <= 1'b0;
            cnt_q    <= 2'h0;
            mem_q[0] <= '0;
            mem_q[1] <= '0;
        end else begin
            if (push) begin
                mem_q[wr_q] <= in_data_i;
                wr_q        <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // msp_skid_buf

/* tb/msp_line_model.sv */
// line partner: async terminal on the data pins and gated link clock
module msp_line_model #(
    parameter int BIT_NS = 160
) (
    input  wire logic tx_line_i,
    input  wire logic run_i,
    output logic      rx_line_o,
    output logic      link_clk_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] got_q[$];
    logic [7:0] c;

    initial begin
        rx_line_o = 1'b1;
        link_clk_o = 1'b0;
    end

    // link clock stands low outside active use
    always begin
        wait (run_i);
        #40 link_clk_o = run_i & ~link_clk_o;
    end

    // decode 7 data bits then parity, sampled mid-bit
    always @(negedge tx_line_i) begin
        #(BIT_NS * 3 / 2);
        for (int i = 0; i < 8; i++) begin
            c[i] = tx_line_i;
            #(BIT_NS);
        end
        got_q.push_back(c);
    end

    task automatic send(input logic [6:0] d, input logic bad_par, input logic bad_stop);
        logic [8:0] f;
        f = {~bad_stop, (^d) ^ bad_par, d};
        rx_line_o = 1'b0;
        #(BIT_NS);
        for (int i = 0; i < 9; i++) begin
            rx_line_o = f[i];
            #(BIT_NS);
        end
        rx_line_o = 1'b1;
        #(BIT_NS * 2);
    endtask
endmodule  // msp_line_model

/* tb/msp_serial_port_tb.sv */
// self-checking bench of the multi-mode serial port
module msp_serial_port_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clock_i, resetn_i, ctl_we, clr_we, fc_we, tx_valid, rx_ready, run;
    logic [15:0] ctl, clr, div, ctl_o;
    logic [1:0]  fc;
    logic [7:0]  tx_data, rx_data, g;
    logic        tx_ready, rx_valid, rx_irq, tx_irq, par_e, frm_e, ovr_e;
    logic        txd, rxd, lclk, clk_oe, fsx_oe;
    logic [6:0]  d;
    logic [7:0]  exp_q[$];
    int          bad_count, checked, n;

    msp_serial_port i_msp_serial_port (.clock_i(clock_i), .resetn_i(resetn_i),
        .serial_control_reg_i(ctl), .serial_control_we_i(ctl_we),
        .serial_control_clear_reg_i(clr), .serial_control_clear_we_i(clr_we),
        .baud_divisor_reg_i(div), .int_flag_clear_reg_i(fc), .int_flag_clear_we_i(fc_we),
        .serial_control_o(ctl_o), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
        .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
        .rx_ready_i(rx_ready), .rx_full_irq(rx_irq), .tx_empty_irq(tx_irq),
        .parity_err_o(par_e), .framing_err_o(frm_e), .overrun_err_o(ovr_e),
        .rx_data_pin_i(rxd), .rx_data_pin_o(), .rx_data_pin_oe_o(),
        .tx_data_pin_o(txd), .tx_clk_pin_i(lclk), .tx_clk_pin_oe_o(clk_oe),
        .codec_rx_bitclock_pin(lclk), .codec_tx_bitclock_pin(lclk),
        .rx_frame_sync_pin_i(1'b0), .rx_frame_sync_pin_o(), .rx_frame_sync_pin_oe_o(),
        .tx_frame_sync_pin_i(1'b0), .tx_frame_sync_pin_o(), .tx_frame_sync_pin_oe_o(fsx_oe));

    msp_line_model i_msp_line_model (.tx_line_i(txd), .run_i(run), .rx_line_o(rxd),
        .link_clk_o(lclk));

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one-cycle write: 0 control, 1 control clear, 2 flag clear
    task automatic wr(input int k, input logic [15:0] v);
        @(posedge clock_i);
        ctl <= v;
        clr <= v;
        fc <= v[1:0];
        ctl_we <= (k == 0);
        clr_we <= (k == 1);
        fc_we <= (k == 2);
        @(posedge clock_i);
        ctl_we <= 1'b0;
        clr_we <= 1'b0;
        fc_we <= 1'b0;
        #1;
    endtask

    task automatic drain;
        @(posedge clock_i);
        rx_ready <= 1'b1;
        repeat (4) @(posedge clock_i);
        rx_ready <= 1'b0;
    endtask

    task automatic final_report;
        $display("counts: checked=%0d bad=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        bad_count++;
        final_report();
    end

    initial begin
        {ctl_we, clr_we, fc_we, tx_valid, rx_ready, run} = 6'h00;
        {ctl, clr, div, fc, tx_data} = '0;
        resetn_i = 1'b0;
        void'($urandom(26568));
        repeat (10) @(posedge clock_i);
        resetn_i <= 1'b1;
        #1;
        check(ctl_o, 16'h0800);
        check({txd, tx_ready, rx_valid, rx_irq, tx_irq}, 5'b11000);
        wr(0, 16'h0800);
        repeat (2) @(posedge clock_i);
        check(clk_oe, 1'b1);
        wr(0, 16'h0820);
        repeat (2) @(posedge clock_i);
        check(clk_oe, 1'b0);
        $display("test sync clock done");
        run = 1'b1;
        wr(0, 16'h0882);
        repeat (4) @(posedge clock_i);
        check(fsx_oe, 1'b1);
        wr(0, 16'h0802);
        repeat (4) @(posedge clock_i);
        check(fsx_oe, 1'b0);
        run = 1'b0;
        $display("test codec sync done");
        div <= 16'h0001;
        wr(0, 16'h081d);
        check(ctl_o, 16'h081d);
        wr(1, 16'h0800);
        check(ctl_o, 16'h001d);
        // fill the send buffer until it refuses
        n = 0;
        @(posedge clock_i);
        tx_data <= 8'($urandom) & 8'h7f;
        tx_valid <= 1'b1;
        repeat (20) begin
            @(posedge clock_i);
            if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
                exp_q.push_back({^tx_data[6:0], tx_data[6:0]});
                n++;
                tx_data <= 8'($urandom) & 8'h7f;
            end
        end
        tx_valid <= 1'b0;
        check(n < 20, 1'b1);
        repeat (n * 200 + 100) @(posedge clock_i);
        check(i_msp_line_model.got_q.size(), n);
        foreach (exp_q[i]) begin
            g = i_msp_line_model.got_q[i];
            check(g, exp_q[i]);
        end
        check(tx_irq, 1'b1);
        wr(2, 16'h0002);
        check(tx_irq, 1'b0);
        $display("test async send done");
        // sync and codec modes received idle-line words earlier
        drain();
        wr(2, 16'h0001);
        check({ovr_e, rx_irq}, 2'b00);
        repeat (3) begin
            d = 7'($urandom);
            i_msp_line_model.send(d, 1'b0, 1'b0);
            check(par_e, 1'b0);
            check(rx_irq, 1'b1);
            check(rx_valid, 1'b1);
            check(rx_data, {1'b0, d});
            drain();
        end
        i_msp_line_model.send(7'h15, 1'b1, 1'b0);
        check(par_e, 1'b1);
        drain();
        i_msp_line_model.send(7'h2a, 1'b0, 1'b1);
        check(frm_e, 1'b1);
        drain();
        repeat (4) i_msp_line_model.send(7'($urandom), 1'b0, 1'b0);
        check(ovr_e, 1'b1);
        drain();
        wr(2, 16'h0001);
        repeat (2) @(posedge clock_i);
        check({ovr_e, rx_irq}, 2'b00);
        $display("test async receive done");
        final_report();
    end
endmodule  // msp_serial_port_tb
